/* File: jpe_jtag_ctrl.sv */
// Model of the external serial test controller on the shared pins.
// Assumes the bench resolves pin levels; the test clock stands still between frames.
`timescale 1ns/1ps
module jpe_jtag_ctrl (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b0;
    o_tdi = 1'b0;
  end
  // One frame: four idle edges first, because the clock stands still between
  // frames and the engine needs them to leave reset and see its enable; then
  // 16 bits, LSB first, then idle edges so the reply can be loaded.
  // Output bits are taken just before each rise, since the device shifts on it.
  task automatic frame(input logic [15:0] w, output logic [15:0] rsp);
    rsp = 16'h0000;
    #3;
    for (int i = 0; i < 30; i++) begin
      o_tms = (i >= 4 && i < 20);
      o_tdi = o_tms ? w[4'(i - 4)] : ~o_tdi;
      #62.5;
      if (i >= 5 && i <= 20) rsp = {i_tdo, rsp[15:1]};
      o_tck = 1'b1;
      #62.5 o_tck = 1'b0;
    end
  endtask : frame
endmodule : jpe_jtag_ctrl

/* File: jpe_link.sv */
// Serial engine on the test clock: frames of 16 bits, LSB first, while tms is high.
// Assumes i_arst is asynchronous; its release is resynchronised here.
`timescale 1ns/1ps
module jpe_link (
  input wire logic i_tck,
  input wire logic i_arst,
  input wire logic i_enable,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  jpe_link_if.link lnk
);
  typedef enum logic {L_IDLE, L_WAIT} jpe_lstate_t;
  jpe_lstate_t state_r;
  logic rs1_r, rs2_r, lrst, en_s, rsp_s, rsp_seen_r, rsp_ev;
  logic [4:0] cnt_r;
  logic [15:0] sh_r, rd_sh_r, cmd_r;
  logic active_r, tgl_r, tdo_r, fr_done, sess_on, sess_off, issue;
  logic [3:0] op;

  // Reset release synchronised to the test clock.
  always_ff @(posedge i_tck or posedge i_arst) begin
    if (i_arst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign lrst = ~rs2_r;

  jpe_sync2 u_en (.i_clk(i_tck), .i_rst(lrst), .i_d(i_enable), .o_q(en_s));
  jpe_sync2 u_rsp (.i_clk(i_tck), .i_rst(lrst), .i_d(lnk.rsp_tgl), .o_q(rsp_s));

  // Frame decoding; a frame is kept only when its bit count is 16 modulo 32, as the counter wraps.
  assign op = sh_r[15:12];
  assign fr_done = en_s & ~i_tms & (cnt_r == 5'(jpe_pkg::FRAME_W));
  assign sess_on = fr_done & (op == jpe_pkg::OP_ENABLE);
  assign sess_off = fr_done & (op == jpe_pkg::OP_DISABLE);
  assign issue = fr_done & active_r & (state_r == L_IDLE) & ~sess_on & ~sess_off;
  assign rsp_ev = rsp_s ^ rsp_seen_r;

  // Shift path and command handshake.
  always_ff @(posedge i_tck or posedge lrst) begin
    if (lrst) begin
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      rd_sh_r <= 16'h0000;
      tdo_r <= 1'b0;
      active_r <= 1'b0;
      tgl_r <= 1'b0;
      cmd_r <= 16'h0000;
      rsp_seen_r <= 1'b0;
      state_r <= L_IDLE;
    end else begin
      cnt_r <= (en_s & i_tms & (cnt_r != 5'h1f)) ? cnt_r + 5'h01 : 5'h00;
      if (en_s & i_tms) begin
        sh_r <= {i_tdi, sh_r[15:1]};
        rd_sh_r <= {1'b0, rd_sh_r[15:1]};
        tdo_r <= rd_sh_r[0];
      end else if (rsp_ev) begin
        rd_sh_r <= {8'h00, lnk.rsp_data};
      end
      rsp_seen_r <= rsp_s;
      active_r <= en_s & (sess_on | (active_r & ~sess_off));
      case (state_r)
        L_IDLE: begin
          if (issue) begin
            cmd_r <= sh_r;
            tgl_r <= ~tgl_r;
            state_r <= L_WAIT;
          end
        end
        L_WAIT: begin
          if (rsp_ev) state_r <= L_IDLE;
        end
        default: state_r <= L_IDLE;
      endcase
    end
  end

  assign lnk.cmd_tgl = tgl_r;
  assign lnk.cmd_word = cmd_r;
  assign lnk.active = active_r;
  assign o_tdo = tdo_r;
  assign o_tdo_oe = active_r & en_s;
endmodule : jpe_link

/* File: jpe_link_if.sv */
// Carrier between the core on i_clk and the serial engine on the test clock.
// Assumes toggle handshakes: each side holds its data until the other toggles back.
`timescale 1ns/1ps
interface jpe_link_if;
  logic cmd_tgl;
  logic [15:0] cmd_word;
  logic active;
  logic rsp_tgl;
  logic [7:0] rsp_data;

  modport link (output cmd_tgl, output cmd_word, output active,
                input rsp_tgl, input rsp_data);
  modport core (input cmd_tgl, input cmd_word, input active,
                output rsp_tgl, output rsp_data);
endinterface : jpe_link_if

/* File: jpe_pin_enable.sv */
// Test-port pin enable: chooses between the serial test port and general I/O
// on four shared pins, and holds the blank-state image and configuration bit.
// Assumes an APB master on i_clk and an external serial controller on i_tck.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module jpe_pin_enable (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_tck,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_test_select_term,
  input wire logic [3:0] i_pin_in,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  output logic o_test_enable
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  jpe_link_if lnk ();

  logic core_rst;
  logic hs_rst;
  logic tpe_r;
  logic ded_r;
  logic [jpe_pkg::IMG_DEPTH-1:0] valid_r;
  logic [7:0] img_mem [jpe_pkg::IMG_DEPTH];
  logic [3:0] gpio_out_r;
  logic [3:0] gpio_dir_r;
  logic [3:0] pin_s;
  logic en_comb;
  logic act_s;
  logic blank;
  logic link_tdo;
  logic link_tdo_oe;

  // APB decode.
  logic setup;
  logic access;
  logic wr_acc;
  logic aligned;
  logic hit_tpe;
  logic hit_cfg;
  logic hit_status;
  logic hit_gpio_out;
  logic hit_gpio_dir;
  logic hit_gpio_in;
  logic hit_image;
  logic [11:0] img_base;
  logic [3:0] bus_img_idx;
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic [31:0] prdata_r;
  logic err_r;

  // Command receive side of the handshake.
  logic cmd_s;
  logic cmd_seen_r;
  logic cmd_ev;
  logic [3:0] cmd_op;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;
  logic img_we;
  logic img_erase;
  logic cfg_we;
  logic rsp_tgl_r;
  logic [7:0] rsp_data_r;
  logic [7:0] rsp_nxt;

  // --------------------------------------------------------------------
  // Image read helper
  // --------------------------------------------------------------------
  // An unprogrammed byte has no stored value yet, so it reads as the
  // erased pattern; only a programming pass marks it valid.
  function automatic logic [7:0] img_rd(input logic vld, input logic [7:0] word);
    return vld ? word : jpe_pkg::BLANK_BYTE;
  endfunction : img_rd

  // --------------------------------------------------------------------
  // Reset domains
  // --------------------------------------------------------------------
  // Device reset and power-on both clear the bus-side registers. The
  // non-volatile image and dedication bit only see power-on, which stands
  // for the factory-blank state here.
  assign core_rst = i_rst | i_por;

  // The link and both ends of its handshake share one reset so that the
  // toggles never disagree after a reset. Device reset reaches it only
  // when the pins are not dedicated; ded_r is a quasi-static bit, so the
  // gate cannot glitch while reset is applied.
  // dedicated pins survive reset
  assign hs_rst = i_por | (i_rst & ~ded_r);

  // --------------------------------------------------------------------
  // Pin enable and pin mux
  // --------------------------------------------------------------------
  // three-way enable OR
  assign en_comb = ded_r | tpe_r | i_test_select_term;
  assign o_test_enable = en_comb;

  // Only the data-out pin is ever driven in test mode; the other three are
  // inputs to the serial engine. In general I/O mode software owns all four.
  // pins return to I/O
  assign o_pin_out = en_comb ? {link_tdo, 3'b000} : gpio_out_r;
  assign o_pin_oe = en_comb ? {link_tdo_oe, 3'b000} : gpio_dir_r;

  // Pin levels cross into i_clk before software can read them.
  jpe_sync2 #(.W(4)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(core_rst),
    .i_d(i_pin_in),
    .o_q(pin_s)
  );

  // Session flag crosses for the status register.
  jpe_sync2 u_act_sync (
    .i_clk(i_clk),
    .i_rst(hs_rst),
    .i_d(lnk.active),
    .o_q(act_s)
  );

  // --------------------------------------------------------------------
  // Serial engine on the test clock
  // --------------------------------------------------------------------
  jpe_link u_link (
    .i_tck(i_tck),
    .i_arst(hs_rst),
    .i_enable(en_comb),
    .i_tms(i_pin_in[jpe_pkg::PIN_TMS]),
    .i_tdi(i_pin_in[jpe_pkg::PIN_TDI]),
    .o_tdo(link_tdo),
    .o_tdo_oe(link_tdo_oe),
    .lnk(lnk.link)
  );

  // --------------------------------------------------------------------
  // APB address decode
  // --------------------------------------------------------------------
  // Registers answer only on aligned words; anything else is an error.
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr_acc = access & i_pwrite;
  assign aligned = (i_paddr[1:0] == 2'b00);
  assign hit_tpe = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_TEST_PORT_EN));
  assign hit_cfg = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_CFG));
  assign hit_status = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_STATUS));
  assign hit_gpio_out = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_GPIO_OUT));
  assign hit_gpio_dir = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_GPIO_DIR));
  assign hit_gpio_in = aligned & (i_paddr == jpe_pkg::reg_addr(jpe_pkg::IDX_GPIO_IN));
  assign img_base = jpe_pkg::reg_addr(jpe_pkg::IDX_IMAGE_BASE);
  assign hit_image = aligned & (i_paddr[11:6] == img_base[11:6]);
  assign bus_img_idx = i_paddr[5:2];

  // Status: the part counts as blank while no byte and no bit is programmed.
  assign blank = ~(|valid_r) & ~ded_r;

  // Read data and error are worked out in the setup phase so that both
  // come from flip-flops in the access phase; this costs nothing because
  // the slave still answers with zero wait states.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit_tpe) begin
      rd_nxt[jpe_pkg::TPE_EN_BIT] = tpe_r;
    end else if (hit_cfg) begin
      rd_nxt[jpe_pkg::CFG_DED_BIT] = ded_r;
    end else if (hit_status) begin
      rd_nxt[jpe_pkg::ST_ENABLE_BIT] = en_comb;
      rd_nxt[jpe_pkg::ST_ACTIVE_BIT] = act_s;
      rd_nxt[jpe_pkg::ST_TERM_BIT] = i_test_select_term;
      rd_nxt[jpe_pkg::ST_BLANK_BIT] = blank;
    end else if (hit_gpio_out) begin
      rd_nxt[3:0] = gpio_out_r;
    end else if (hit_gpio_dir) begin
      rd_nxt[3:0] = gpio_dir_r;
    end else if (hit_gpio_in) begin
      rd_nxt[3:0] = pin_s;
    end else if (hit_image) begin
      rd_nxt[7:0] = img_rd(valid_r[bus_img_idx], img_mem[bus_img_idx]);
    end else begin
      err_nxt = 1'b1;
    end
  end

  // Read data and error latch in setup.
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= i_pwrite ? 32'h0000_0000 : rd_nxt;
      err_r <= err_nxt;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = 1'b1;
  assign o_pslverr = access & err_r;

  // --------------------------------------------------------------------
  // Software-written registers
  // --------------------------------------------------------------------
  // Only bit 0 is stored; the unused bits have no storage and read zero,
  // so a careless nonzero write to them does no harm.
  // reset and software clear
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      tpe_r <= jpe_pkg::TPE_RST;
    end else if (wr_acc & hit_tpe) begin
      tpe_r <= i_pwdata[jpe_pkg::TPE_EN_BIT];
    end
  end

  // General I/O output and direction.
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      gpio_out_r <= jpe_pkg::GPIO_RST;
      gpio_dir_r <= jpe_pkg::GPIO_RST;
    end else if (wr_acc) begin
      if (hit_gpio_out) gpio_out_r <= i_pwdata[3:0];
      if (hit_gpio_dir) gpio_dir_r <= i_pwdata[3:0];
    end
  end

  // --------------------------------------------------------------------
  // Commands from the serial engine
  // --------------------------------------------------------------------
  // The command word is held by the engine until the answer toggles back,
  // so it may be read directly once the toggle has been synchronised.
  jpe_sync2 u_cmd_sync (
    .i_clk(i_clk),
    .i_rst(hs_rst),
    .i_d(lnk.cmd_tgl),
    .o_q(cmd_s)
  );

  assign cmd_ev = cmd_s ^ cmd_seen_r;
  assign cmd_op = lnk.cmd_word[15:12];
  assign cmd_addr = lnk.cmd_word[11:8];
  assign cmd_data = lnk.cmd_word[7:0];
  assign img_we = cmd_ev & (cmd_op == jpe_pkg::OP_WR_IMAGE);
  assign img_erase = cmd_ev & (cmd_op == jpe_pkg::OP_ERASE);
  assign cfg_we = cmd_ev & (cmd_op == jpe_pkg::OP_WR_CFG);
  assign rsp_nxt = (cmd_op == jpe_pkg::OP_RD_IMAGE) ?
    img_rd(valid_r[cmd_addr], img_mem[cmd_addr]) :
    (cmd_op == jpe_pkg::OP_RD_CFG) ? {7'h00, ded_r} : 8'h00;

  // Every command is answered, so the engine never waits forever.
  always_ff @(posedge i_clk or posedge hs_rst) begin
    if (hs_rst) begin
      cmd_seen_r <= 1'b0;
      rsp_tgl_r <= 1'b0;
      rsp_data_r <= 8'h00;
    end else begin
      cmd_seen_r <= cmd_s;
      if (cmd_ev) begin
        rsp_data_r <= rsp_nxt;
        rsp_tgl_r <= ~rsp_tgl_r;
      end
    end
  end

  assign lnk.rsp_tgl = rsp_tgl_r;
  assign lnk.rsp_data = rsp_data_r;

  // --------------------------------------------------------------------
  // Non-volatile image and configuration
  // --------------------------------------------------------------------
  // Power-on stands for the factory-blank state: no byte valid and the
  // dedication bit clear. A full erase from the link returns to it.
  // blank until programmed
  always_ff @(posedge i_clk or posedge i_por) begin
    if (i_por) begin
      valid_r <= '0;
    end else if (img_erase) begin
      valid_r <= '0;
    end else if (img_we) begin
      valid_r[cmd_addr] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_por) begin
    if (i_por) begin
      ded_r <= jpe_pkg::CFG_BLANK;
    end else if (img_erase) begin
      ded_r <= jpe_pkg::CFG_BLANK;
    end else if (cfg_we) begin
      ded_r <= cmd_data[0];
    end
  end

  // Storage array; contents before programming are masked by valid_r.
  always_ff @(posedge i_clk) begin
    if (img_we) begin
      img_mem[cmd_addr] <= cmd_data;
    end
  end

endmodule : jpe_pin_enable

/* File: jpe_pin_enable_props.sv */
// Checker for the test-port pin enable block, bound to the top module ports.
// Assumes one core clock; either reset input disables every check.
`timescale 1ns/1ps
module jpe_pin_enable_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_tck,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_test_select_term,
  input wire logic [3:0] i_pin_in,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe,
  input wire logic o_test_enable
);
  localparam logic [11:0] A_EN = {2'b00, jpe_pkg::IDX_TEST_PORT_EN, 2'b00};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || i_por);
  // --------------------------------------------------------------------
  // Bus phases of a write that sets the enable bit
  // --------------------------------------------------------------------
  sequence s_setup_en;
    i_psel && !i_penable && i_pwrite && i_paddr == A_EN && i_pwdata[0];
  endsequence
  sequence s_access_en;
    i_psel && i_penable && i_pwrite && i_paddr == A_EN && i_pwdata[0];
  endsequence
  chk_en_write: assert property (s_setup_en ##1 s_access_en |=> o_test_enable [*2])
    else $error("enable bit write did not enable the port");
  chk_term_or: assert property (i_test_select_term |-> o_test_enable)
    else $error("select term did not enable the port");
  chk_pins_test: assert property (o_test_enable |-> o_pin_oe[2:0] == 3'b000)
    else $error("input pins driven while the port is enabled");
  chk_pins_out: assert property (o_test_enable |-> o_pin_out[2:0] == 3'b000)
    else $error("pin drive values wrong while the port is enabled");
  chk_ready_access: assert property (i_psel && i_penable |-> o_pready)
    else $error("no ready in access phase");
  chk_err_setup: assert property (i_psel && !i_penable |-> !o_pslverr)
    else $error("error flagged in setup phase");
  chk_err_align: assert property (i_psel && i_penable && i_paddr[1:0] != 2'b00 |-> o_pslverr)
    else $error("misaligned access not refused");
  chk_en_read: assert property (i_psel && i_penable && !i_pwrite && i_paddr == A_EN
    |-> o_prdata[31:1] == 31'h0 && (!o_prdata[0] || o_test_enable))
    else $error("enable register read back wrong");
endmodule : jpe_pin_enable_props

/* File: jpe_pkg.sv */
// Shared constants for the test-port pin enable block.
// Assumes a 32-bit APB slave on i_clk and a serial link clocked by the test clock pin.
package jpe_pkg;

  // --------------------------------------------------------------------
  // Bus and register map
  // --------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [7:0] IDX_TEST_PORT_EN = 8'hc7;
  localparam logic [7:0] IDX_CFG = 8'hc0;
  localparam logic [7:0] IDX_STATUS = 8'hc1;
  localparam logic [7:0] IDX_GPIO_OUT = 8'hc2;
  localparam logic [7:0] IDX_GPIO_DIR = 8'hc3;
  localparam logic [7:0] IDX_GPIO_IN = 8'hc4;
  localparam logic [7:0] IDX_IMAGE_BASE = 8'hd0;

  // Field positions.
  localparam int TPE_EN_BIT = 0;
  localparam int CFG_DED_BIT = 0;
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_TERM_BIT = 2;
  localparam int ST_BLANK_BIT = 3;

  // Reset and blank values.
  localparam logic TPE_RST = 1'b0;
  localparam logic CFG_BLANK = 1'b0;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam logic [7:0] BLANK_BYTE = 8'hff;

  // --------------------------------------------------------------------
  // Shared pins and link frames
  // --------------------------------------------------------------------
  localparam int NPINS = 4;
  localparam int PIN_TMS = 0;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;
  localparam int FRAME_W = 16;
  localparam int IMG_AW = 4;
  localparam int IMG_DEPTH = 16;
  localparam logic [3:0] OP_DISABLE = 4'h0;
  localparam logic [3:0] OP_ENABLE = 4'h1;
  localparam logic [3:0] OP_WR_IMAGE = 4'h2;
  localparam logic [3:0] OP_WR_CFG = 4'h3;
  localparam logic [3:0] OP_RD_IMAGE = 4'h4;
  localparam logic [3:0] OP_ERASE = 4'h5;
  localparam logic [3:0] OP_RD_CFG = 4'h6;

  // Byte address of a register from its index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : reg_addr

endpackage : jpe_pkg

/* File: jpe_sync2.sv */
// Two-flop synchroniser for levels of width W.
// Assumes the input changes no faster than the receiving clock can see.
`timescale 1ns/1ps
module jpe_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // The first stage feeds only the second.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule : jpe_sync2

/* File: testbench.sv */
// Self-checking bench for the test-port pin enable block.
// Assumes the controller model and the checker files are compiled before it.
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] A_EN = {2'b00, jpe_pkg::IDX_TEST_PORT_EN, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, jpe_pkg::IDX_CFG, 2'b00};
  localparam logic [11:0] A_GOUT = {2'b00, jpe_pkg::IDX_GPIO_OUT, 2'b00};
  localparam logic [11:0] A_GDIR = {2'b00, jpe_pkg::IDX_GPIO_DIR, 2'b00};
  localparam logic [11:0] A_ST = {2'b00, jpe_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_GIN = {2'b00, jpe_pkg::IDX_GPIO_IN, 2'b00};
  localparam logic [11:0] A_IMG = {2'b00, jpe_pkg::IDX_IMAGE_BASE, 2'b00};
  localparam logic [32:0] ERR = 33'h100000000;
  logic clk, rst, por, psel, penable, pwrite, term;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ten, tck, tms, tdi;
  wire logic [3:0] pout, poe, lvl;
  int error_cnt, n_compared, seed;
  logic [32:0] notes[$];
  logic [15:0] rsp;
  logic [7:0] d;
  // Pin levels: a driven pin shows the device, a released one the controller.
  // The data-out pin is pulled up, so a silent device reads as ones.
  assign lvl = (poe & pout) | (~poe & {1'b1, tdi, tck, tms});
  jpe_pin_enable u_jpe_pin_enable (.i_clk(clk), .i_rst(rst), .i_por(por), .i_tck(lvl[1]),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_test_select_term(term), .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe(poe),
    .o_test_enable(ten));
  jpe_jtag_ctrl u_jpe_jtag_ctrl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(lvl[3]));
  always #4 clk = ~clk;
  // --------------------------------------------------------------------
  // Compare, bus and reset tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One transfer; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    notes.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : do_rst
  // Read monitor: takes the oldest note at each completed read; data is ignored on errors.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
      chk({pslverr, pslverr === 1'b1 ? 32'h0 : prdata}, notes.pop_front(), "read");
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    #500000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    seed = 1;
    clk = 1'b0;
    {rst, por, psel, penable, pwrite, term, paddr, pwdata} = {2'b11, 48'h0};
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(A_EN, 33'h0);
    rd(A_CFG, 33'h0);
    for (int i = 0; i < 16; i++) rd(A_IMG + 12'(4 * i), 33'h0ff);
    $display("blank state test done");
    apb(1'b1, A_EN, 32'h1);
    chk(ten, 1'b1, "enable");
    chk(poe[2:0], 3'b000, "pins");
    rd(A_EN, 33'h1);
    apb(1'b1, A_EN, 32'h0);
    chk(ten, 1'b0, "cleared");
    d = 8'($random(seed));
    apb(1'b1, A_GOUT, {28'h0, d[3:0]});
    apb(1'b1, A_GDIR, {28'h0, d[7:4]});
    chk({poe, pout}, d, "gpio");
    // Two edges let the pin levels through the input synchroniser.
    repeat (2) @(posedge clk);
    rd(A_GIN, {29'h0, (d[7:4] & d[3:0]) | (~d[7:4] & 4'h8)});
    @(posedge clk);
    term <= 1'b1;
    @(posedge clk);
    #1;
    chk(ten, 1'b1, "term");
    @(posedge clk);
    term <= 1'b0;
    rd(12'h3fc, ERR);
    apb(1'b1, A_EN + 12'h1, 32'h1);
    chk(ten, 1'b0, "misaligned write");
    $display("register and pin test done");
    apb(1'b1, A_EN, 32'h1);
    u_jpe_jtag_ctrl.frame(16'h1000, rsp);
    chk(poe[3], 1'b1, "session");
    rd(A_ST, 33'h00000000b);
    u_jpe_jtag_ctrl.frame({8'h23, d}, rsp);
    rd(A_IMG + 12'hc, {25'h0, d});
    do_rst();
    chk({ten, poe[3]}, 2'b00, "abort");
    apb(1'b1, A_EN, 32'h1);
    u_jpe_jtag_ctrl.frame(16'h43_00, rsp);
    u_jpe_jtag_ctrl.frame(16'h6000, rsp);
    chk(rsp, 16'hffff, "blocked");
    $display("register enable reset test done");
    u_jpe_jtag_ctrl.frame(16'h1000, rsp);
    u_jpe_jtag_ctrl.frame(16'h3001, rsp);
    rd(A_CFG, 33'h1);
    apb(1'b1, A_EN, 32'h0);
    chk(ten, 1'b1, "dedicated");
    do_rst();
    chk(ten, 1'b1, "kept");
    u_jpe_jtag_ctrl.frame(16'h4300, rsp);
    u_jpe_jtag_ctrl.frame(16'h6000, rsp);
    chk(rsp, {8'h00, d}, "image reply");
    u_jpe_jtag_ctrl.frame(16'h0000, rsp);
    chk(rsp, 16'h0001, "cfg reply");
    chk({ten, poe[3]}, 2'b10, "session closed");
    u_jpe_jtag_ctrl.frame(16'h1000, rsp);
    u_jpe_jtag_ctrl.frame(16'h5000, rsp);
    rd(A_IMG + 12'hc, 33'h0ff);
    rd(A_CFG, 33'h0);
    chk(ten, 1'b0, "erased");
    $display("dedicated reset test done");
    give_verdict();
  end
endmodule : testbench
bind jpe_pin_enable jpe_pin_enable_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_por(i_por), .i_tck(i_tck), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_test_select_term(i_test_select_term),
  .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_test_enable(o_test_enable));
